// >>> rtl/ebr_pkg.sv
// shared constants and carrier types of the embedded ram block
// assumes one 25 MHz clock and plain-port configuration, no register bus
package ebr_pkg;
  localparam int BLOCK_BITS = 4608;
  localparam int ENTRIES = 512;
  localparam int ENTRY_W = 9;
  localparam int BYTE_W = 8;
  localparam int MAX_W = 36;
  localparam int ADDR_W = 12;
  localparam int ENT_W = 9;
  localparam int BE_W = 4;
  localparam int DEF_MAX_TAPS = 4;
  // width codes: data width is 1 << code, parity widths are 9, 18, 36
  localparam logic [2:0] W1 = 3'h0;
  localparam logic [2:0] W2 = 3'h1;
  localparam logic [2:0] W4 = 3'h2;
  localparam logic [2:0] W8 = 3'h3;
  localparam logic [2:0] W16 = 3'h4;
  localparam logic [2:0] W32 = 3'h5;

  typedef enum logic [2:0] {
    EBR_TDP, EBR_SDP, EBR_SP, EBR_ROM, EBR_SPLIT, EBR_SHIFT
  } ebr_mode_t;

  typedef struct packed {
    logic en;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [MAX_W-1:0] wdata;
    logic [BE_W-1:0] be;
  } ebr_req_t;

  typedef struct packed {
    ebr_mode_t mode;
    logic [2:0] a_wcode;
    logic [2:0] b_wcode;
    logic parity;
    logic a_outreg;
    logic b_outreg;
    logic pseudo_async;
    logic [ADDR_W-1:0] tap_len;
    logic [2:0] tap_cnt;
  } ebr_cfg_t;
endpackage

// >>> rtl/ebr_rd_pipe.sv
// read data stage of one port: optional output register
// assumes array data and its valid arrive combinationally from the captured address
`timescale 1ns/10ps
`default_nettype none
module ebr_rd_pipe #(
  parameter int W = 36
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // array side
  input wire logic outreg,
  input wire logic in_vld,
  input wire logic [W-1:0] in_data,
  // user side
  output logic out_vld,
  output logic [W-1:0] out_data
);
  import ebr_pkg::*;

  if (W < 1 || W > MAX_W) begin : g_bad_w
    $error("read pipe width out of range");
  end

  typedef struct packed {
    logic s1_vld;
    logic [W-1:0] s1;
    logic q_vld;
    logic [W-1:0] q;
  } ebr_pipe_st_t;

  ebr_pipe_st_t st;
  ebr_pipe_st_t next_st;

  // both paths end in the same flop so the port never sees a mux after it
  always_comb begin
    next_st = st;
    next_st.s1_vld = in_vld;
    next_st.s1 = in_data;
    if (outreg) begin // R7
      next_st.q_vld = st.s1_vld;
      next_st.q = st.s1;
    end else begin
      next_st.q_vld = in_vld;
      next_st.q = in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign out_vld = st.q_vld;
  assign out_data = st.q;

  chk_pipe_two_stage: assert property (@(posedge clk) disable iff (!resetn) // R18
    (in_vld && outreg) ##1 outreg |=> out_vld && out_data == $past(in_data, 2))
    else $error("registered read data not two clocks late");
endmodule // ebr_rd_pipe
`default_nettype wire

// >>> rtl/ebr_embedded_ram_block.sv
// embedded ram block: 4608-bit array with two ports, modes, parity, byte masks
// assumes one clock; each port's own rate is given by its enable pulse
// How it works
// R1: true dual-port lets both ports read or write independently each cycle
// R2: simple dual-port: port a only writes, port b only reads, same cycle
// R3: single-port uses port a alone; read and write exclusive by we
// R4: split mode gives each port its own half of the array
// R5: mixed widths map bit-linearly onto the same storage
// R6: all port inputs are captured; writes fire from the captured copy; the code writes preload data straight from pre_we, pre_addr and pre_data
// R7: each read port has a bypassable output register
// R8: simple dual-port pseudo-asynchronous read takes b address uncaptured; the code does so only while b_outreg is clear
// R9: preload port fills the array before use; reset leaves it intact
// R10: every byte has a ninth bit kept with it
// R11: writes 8 or more bits wide touch only bytes whose enable is set; 1, 2 and 4 bit writes ignore it
// R12: shift size w*len*taps must fit 4608 bits; the code takes w as 1 << code, so parity bits are left out of the size
// R13: tap outputs taps*w must fit the 36-bit port
// R14: shift mode reads old value and writes new one each enabled cycle
// R15: shapes 4096x1 up to 128x32 or 128x36 via width codes
// R16: 32 and 36 wide shapes refused in true dual-port mode
// R17: parity widths never mix with plain widths
// R18: read data one clock after capture, two with output register
// R19: rom mode ignores every write request
`timescale 1ns/10ps
`default_nettype none
module ebr_embedded_ram_block #(
  parameter int MAX_TAPS = ebr_pkg::DEF_MAX_TAPS
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // configuration
  input wire ebr_pkg::ebr_cfg_t cfg,
  // preload
  input wire logic pre_we,
  input wire logic [ebr_pkg::ENT_W-1:0] pre_addr,
  input wire logic [ebr_pkg::ENTRY_W-1:0] pre_data,
  // user ports
  input wire ebr_pkg::ebr_req_t a_req,
  input wire ebr_pkg::ebr_req_t b_req,
  // read data and status
  output logic a_rvld,
  output logic [ebr_pkg::MAX_W-1:0] a_rdata,
  output logic b_rvld,
  output logic [ebr_pkg::MAX_W-1:0] b_rdata,
  output logic cfg_err
);
  import ebr_pkg::*;

  if (MAX_TAPS < 1 || MAX_TAPS > 4) begin : g_bad_taps
    $error("tap count parameter out of range");
  end

  typedef struct packed {
    ebr_req_t a;
    ebr_req_t b;
    logic [ADDR_W-1:0] ptr;
    logic cfg_err;
  } ebr_st_t;

  ebr_st_t st;
  ebr_st_t next_st;
  logic [ENTRY_W-1:0] mem [ENTRIES]; // R10
  logic wr_a_go, rd_a_go, wr_b_go, rd_b_go, sh_go, ok;
  logic [ADDR_W-1:0] addr_b, sh_len, tap_d, tap_a;
  logic [ENT_W-1:0] ent_a, ent_b, ent_t;
  logic [2:0] off_a, off_b, off_t;
  logic [MAX_W-1:0] rd_a, rd_b, sh_out;
  logic [23:0] sh_size;

  function automatic logic [ENT_W-1:0] ent_of(input logic [2:0] wc, input logic [ADDR_W-1:0] ad);
    if (wc < W8) begin
      ent_of = ENT_W'(ad >> (W8 - wc)); // R5
    end else begin
      ent_of = ENT_W'(ad << (wc - W8));
    end
  endfunction

  function automatic logic [2:0] off_of(input logic [2:0] wc, input logic [ADDR_W-1:0] ad);
    logic [2:0] lo;
    lo = ad[2:0] & 3'(8'h7 >> wc);
    off_of = (wc < W8) ? 3'(lo << wc) : 3'h0;
  endfunction

  function automatic logic [MAX_W-1:0] rd_word(input logic [2:0] wc, input logic par,
                                               input logic [ENT_W-1:0] e, input logic [2:0] o);
    rd_word = '0;
    for (int i = 0; i < 4; i++) begin
      if (wc < W8) begin
        if (i < (1 << wc)) begin
          rd_word[i] = mem[e][3'(o + 3'(i))];
        end
      end else if (i < (1 << (wc - W8))) begin
        if (par) begin
          rd_word[i*9 +: 9] = mem[ENT_W'(e + ENT_W'(i))];
        end else begin
          rd_word[i*8 +: 8] = mem[ENT_W'(e + ENT_W'(i))][BYTE_W-1:0];
        end
      end
    end
  endfunction

  task automatic put(input logic [2:0] wc, input logic par, input logic [ENT_W-1:0] e,
                     input logic [2:0] o, input ebr_req_t r);
    for (int i = 0; i < 4; i++) begin
      if (wc < W8) begin
        if (i < (1 << wc)) begin
          mem[e][3'(o + 3'(i))] <= r.wdata[i];
        end
      end else if (i < (1 << (wc - W8)) && r.be[i]) begin // R11
        if (par) begin
          mem[ENT_W'(e + ENT_W'(i))] <= r.wdata[i*9 +: 9];
        end else begin
          mem[ENT_W'(e + ENT_W'(i))][BYTE_W-1:0] <= r.wdata[i*8 +: 8];
        end
      end
    end
  endtask

  // entry decode per port; split pins each port into its own half
  always_comb begin
    addr_b = (cfg.mode == EBR_SDP && cfg.pseudo_async && !cfg.b_outreg) ? b_req.addr : st.b.addr; // R8
    ent_a = ent_of(cfg.a_wcode, st.a.addr);
    ent_b = ent_of(cfg.b_wcode, addr_b);
    off_a = off_of(cfg.a_wcode, st.a.addr);
    off_b = off_of(cfg.b_wcode, addr_b);
    if (cfg.mode == EBR_SPLIT) begin // R4
      ent_a[ENT_W-1] = 1'b0;
      ent_b[ENT_W-1] = 1'b1;
    end
  end

  // port roles per mode; writes use only captured inputs
  always_comb begin
    ok = !st.cfg_err;
    wr_a_go = ok && st.a.en && st.a.we && cfg.mode inside {EBR_TDP, EBR_SDP, EBR_SP, EBR_SPLIT}; // R6 R19
    rd_a_go = ok && st.a.en && !st.a.we && cfg.mode inside {EBR_TDP, EBR_SP, EBR_ROM, EBR_SPLIT}; // R3
    wr_b_go = ok && st.b.en && st.b.we && cfg.mode inside {EBR_TDP, EBR_SPLIT}; // R1 R2
    if (cfg.mode == EBR_SDP) begin // R2
      rd_b_go = ok && ((cfg.pseudo_async && !cfg.b_outreg) ? b_req.en : st.b.en);
    end else begin
      rd_b_go = ok && st.b.en && !st.b.we && cfg.mode inside {EBR_TDP, EBR_ROM, EBR_SPLIT};
    end
    sh_go = ok && st.a.en && cfg.mode == EBR_SHIFT;
  end

  // shift taps: tap k sees data (k+1)*len enabled cycles old
  always_comb begin
    sh_len = ADDR_W'(cfg.tap_len * cfg.tap_cnt);
    sh_out = '0;
    tap_d = '0;
    tap_a = '0;
    ent_t = '0;
    off_t = '0;
    for (int k = 0; k < MAX_TAPS; k++) begin
      if (k < cfg.tap_cnt) begin
        tap_d = ADDR_W'(cfg.tap_len * (k + 1));
        tap_a = (st.ptr >= tap_d) ? ADDR_W'(st.ptr - tap_d) : ADDR_W'(st.ptr + sh_len - tap_d);
        ent_t = ent_of(cfg.a_wcode, tap_a);
        off_t = off_of(cfg.a_wcode, tap_a);
        sh_out = sh_out | (rd_word(cfg.a_wcode, cfg.parity, ent_t, off_t) << (k << cfg.a_wcode)); // R14
      end
    end
  end

  always_comb begin
    rd_a = rd_word(cfg.a_wcode, cfg.parity, ent_a, off_a); // R5
    rd_b = (cfg.mode == EBR_SHIFT) ? sh_out : rd_word(cfg.b_wcode, cfg.parity, ent_b, off_b);
  end

  always_comb begin
    next_st = st;
    next_st.a = a_req; // R6
    next_st.b = b_req;
    // widened first so a large tap product cannot wrap and pass as legal
    sh_size = (24'(cfg.tap_len) * 24'(cfg.tap_cnt)) << cfg.a_wcode;
    next_st.cfg_err = (cfg.a_wcode > W32) || (cfg.b_wcode > W32)
      || (cfg.mode == EBR_TDP && (cfg.a_wcode == W32 || cfg.b_wcode == W32)) // R16 R15
      || (cfg.parity && (cfg.a_wcode < W8 || cfg.b_wcode < W8)) // R17
      || (cfg.mode == EBR_SHIFT && (cfg.tap_cnt == 3'h0 || cfg.tap_len == '0
        || int'(cfg.tap_cnt) > MAX_TAPS || sh_size > 24'(BLOCK_BITS) // R12
        || (int'(cfg.tap_cnt) << cfg.a_wcode) > MAX_W)); // R13
    if (cfg.mode != EBR_SHIFT) begin
      next_st.ptr = '0;
    end else if (sh_go) begin // R14
      next_st.ptr = (st.ptr + 12'h001 >= sh_len) ? '0 : ADDR_W'(st.ptr + 12'h001);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // array contents have no reset so preloaded data survives it
  always_ff @(posedge clk) begin
    if (pre_we) begin // R9
      mem[pre_addr] <= pre_data;
    end else begin
      if (sh_go) begin
        put(cfg.a_wcode, cfg.parity, ent_of(cfg.a_wcode, st.ptr), off_of(cfg.a_wcode, st.ptr), st.a);
      end
      if (wr_a_go) begin
        put(cfg.a_wcode, cfg.parity, ent_a, off_a, st.a);
      end
      if (wr_b_go) begin // R1
        put(cfg.b_wcode, cfg.parity, ent_b, off_b, st.b);
      end
    end
  end

  ebr_rd_pipe #(.W(MAX_W)) u_pipe_a (
    .clk(clk),
    .resetn(resetn),
    .outreg(cfg.a_outreg),
    .in_vld(rd_a_go),
    .in_data(rd_a),
    .out_vld(a_rvld),
    .out_data(a_rdata)
  ); // R18

  ebr_rd_pipe #(.W(MAX_W)) u_pipe_b (
    .clk(clk),
    .resetn(resetn),
    .outreg(cfg.b_outreg),
    .in_vld(rd_b_go || sh_go),
    .in_data(rd_b),
    .out_vld(b_rvld),
    .out_data(b_rdata)
  );

  assign cfg_err = st.cfg_err;

  logic [ENTRY_W-1:0] old_a;
  always_ff @(posedge clk) begin
    old_a <= mem[ent_a];
  end

  chk_rom_no_write: assert property (@(posedge clk) disable iff (!resetn) // R19
    cfg.mode == EBR_ROM |-> !wr_a_go && !wr_b_go && !sh_go) else $error("rom accepted a write");
  chk_sp_exclusive: assert property (@(posedge clk) disable iff (!resetn) // R3
    cfg.mode == EBR_SP |-> !(wr_a_go && rd_a_go) && !wr_b_go && !rd_b_go)
    else $error("single port overlap");
  chk_sdp_roles: assert property (@(posedge clk) disable iff (!resetn) // R2
    cfg.mode == EBR_SDP |-> !wr_b_go && !rd_a_go) else $error("simple dual-port role broken");
  chk_write_captured: assert property (@(posedge clk) disable iff (!resetn) // R6
    wr_a_go |-> $past(a_req.en) && $past(a_req.we)) else $error("write not from captured inputs");
  chk_bypass_delay: assert property (@(posedge clk) disable iff (!resetn) // R18
    (rd_a_go && !cfg.a_outreg) |=> a_rvld && a_rdata == $past(rd_a))
    else $error("bypassed read not one clock late");
  chk_tdp_wide_err: assert property (@(posedge clk) disable iff (!resetn) // R16
    (cfg.mode == EBR_TDP && cfg.b_wcode == W32) |=> cfg_err) else $error("wide dual-port not refused");
  chk_byte_mask: assert property (@(posedge clk) disable iff (!resetn) // R11
    (wr_a_go && cfg.a_wcode == W8 && !st.a.be[0] && !wr_b_go && !pre_we)
    |=> mem[$past(ent_a)] == old_a) else $error("masked byte changed");
  chk_split_half: assert property (@(posedge clk) disable iff (!resetn) // R4
    (cfg.mode == EBR_SPLIT && (wr_a_go || wr_b_go)) |-> !ent_a[ENT_W-1] && ent_b[ENT_W-1])
    else $error("split halves crossed");
  chk_pseudo_read: assert property (@(posedge clk) disable iff (!resetn) // R8
    (!st.cfg_err && cfg.mode == EBR_SDP && cfg.pseudo_async && !cfg.b_outreg && b_req.en)
    |=> b_rvld) else $error("pseudo read missing");
  chk_shift_step: assert property (@(posedge clk) disable iff (!resetn) // R14
    (sh_go && st.ptr + 12'h001 < sh_len) |=> st.ptr == $past(st.ptr) + 12'h001)
    else $error("shift pointer stalled");

  cov_dual_write: cover property (@(posedge clk) disable iff (!resetn) wr_a_go && wr_b_go);
  cov_rom_read: cover property (@(posedge clk) disable iff (!resetn)
    cfg.mode == EBR_ROM && rd_b_go ##1 b_rvld);
  cov_shift_taps: cover property (@(posedge clk) disable iff (!resetn) sh_go && cfg.tap_cnt > 3'h1);
endmodule // ebr_embedded_ram_block
`default_nettype wire

// >>> tb/ebr_fabric_port.sv
// fabric-side user logic model driving one port of the embedded ram block
// assumes the shared clk; each access is one enabled cycle
`timescale 1ns/10ps
`default_nettype none
module ebr_fabric_port (
  // clock
  input wire logic clk,
  // request toward the block
  output var ebr_pkg::ebr_req_t req
);
  import ebr_pkg::*;
  initial req = '0;
  // one request cycle, launched 1 ns after an edge and held until the capture edge
  task automatic access(input logic we, input logic [ADDR_W-1:0] ad,
                        input logic [MAX_W-1:0] wd, input logic [BE_W-1:0] be);
    @(posedge clk);
    #1;
    req = '{en: 1'b1, we: we, addr: ad, wdata: wd, be: be};
    @(posedge clk);
    #1;
    // released lines show the inverse so stale values never look valid
    req = '{en: 1'b0, we: ~we, addr: ~ad, wdata: ~wd, be: ~be};
  endtask
endmodule // ebr_fabric_port
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the embedded ram block
// assumes the 25 MHz clock and fixed read latencies of one or two clocks
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import ebr_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  ebr_cfg_t cfg = '0;
  logic pre_we = 1'b0;
  logic [ENT_W-1:0] pre_addr = '0;
  logic [ENTRY_W-1:0] pre_data = '0;
  ebr_req_t a_req;
  ebr_req_t b_req;
  logic a_rvld;
  logic b_rvld;
  logic cfg_err;
  logic [MAX_W-1:0] a_rdata;
  logic [MAX_W-1:0] b_rdata;
  int error_cnt = 0;
  int total_checks = 0;

  always #20 clk = ~clk;

  ebr_fabric_port ua (.clk(clk), .req(a_req));
  ebr_fabric_port ub (.clk(clk), .req(b_req));
  ebr_embedded_ram_block uut (.clk(clk), .resetn(resetn), .cfg(cfg), .pre_we(pre_we),
    .pre_addr(pre_addr), .pre_data(pre_data), .a_req(a_req), .b_req(b_req),
    .a_rvld(a_rvld), .a_rdata(a_rdata), .b_rvld(b_rvld), .b_rdata(b_rdata),
    .cfg_err(cfg_err));

  task automatic complete_run();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [MAX_W-1:0] got, input logic [MAX_W-1:0] exp,
                       input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // cfg is a level; settle a few cycles so the late legality flag is current
  task automatic set_cfg(input ebr_mode_t m, input logic [2:0] aw, input logic [2:0] bw,
                         input logic par, input logic bor, input logic err);
    cfg = '{mode: m, a_wcode: aw, b_wcode: bw, parity: par, a_outreg: 1'b0,
            b_outreg: bor, pseudo_async: 1'b0, tap_len: 12'h001, tap_cnt: 3'h1};
    repeat (3) @(posedge clk);
    #1;
    check({35'h0, cfg_err}, {35'h0, err}, "config flag");
  endtask

  // tap sizing is a level too; same settle time as set_cfg
  task automatic set_taps(input logic [ADDR_W-1:0] len, input logic [2:0] cnt, input logic err);
    cfg.tap_len = len;
    cfg.tap_cnt = cnt;
    repeat (3) @(posedge clk);
    #1;
    check({35'h0, cfg_err}, {35'h0, err}, "tap sizing flag");
  endtask

  task automatic rd(input logic pb, input logic [ADDR_W-1:0] ad, input logic orq,
                    input logic [MAX_W-1:0] exp);
    if (pb) ub.access(1'b0, ad, 36'h0, 4'h0);
    else ua.access(1'b0, ad, 36'h0, 4'h0);
    @(posedge clk);
    #1;
    if (orq) begin
      check({35'h0, pb ? b_rvld : a_rvld}, 36'h0, "valid too early");
      @(posedge clk);
      #1;
    end
    check({35'h0, pb ? b_rvld : a_rvld}, 36'h1, "read valid");
    check(pb ? b_rdata : a_rdata, exp, "read data");
  endtask

  task automatic s_tdp();
    set_cfg(EBR_TDP, W16, W16, 1'b0, 1'b0, 1'b0);
    ua.access(1'b1, 12'h003, 36'h1234, 4'h3);
    ua.access(1'b1, 12'h003, 36'hABCD, 4'h2);
    rd(1'b1, 12'h003, 1'b0, 36'hAB34);
    fork
      ua.access(1'b1, 12'h005, 36'h5555, 4'h3);
      ub.access(1'b1, 12'h006, 36'h6666, 4'h3);
    join
    rd(1'b0, 12'h006, 1'b0, 36'h6666);
    rd(1'b1, 12'h005, 1'b0, 36'h5555);
  endtask

  task automatic s_outreg();
    set_cfg(EBR_TDP, W16, W16, 1'b0, 1'b1, 1'b0);
    rd(1'b1, 12'h003, 1'b1, 36'hAB34);
    cfg.a_outreg = 1'b1;
    rd(1'b0, 12'h003, 1'b1, 36'hAB34);
  endtask

  task automatic s_mixed();
    set_cfg(EBR_TDP, W1, W16, 1'b0, 1'b0, 1'b0);
    ua.access(1'b1, 12'h030, 36'h1, 4'h0);
    rd(1'b1, 12'h003, 1'b0, 36'hAB35);
  endtask

  task automatic s_parity();
    set_cfg(EBR_TDP, W8, W8, 1'b1, 1'b0, 1'b0);
    ua.access(1'b1, 12'h01E, 36'h1C3, 4'h1);
    rd(1'b1, 12'h01E, 1'b0, 36'h1C3);
    ua.access(1'b1, 12'h01E, 36'h0FF, 4'h0);
    rd(1'b1, 12'h01E, 1'b0, 36'h1C3);
  endtask

  task automatic s_rom();
    @(posedge clk);
    #1;
    pre_we = 1'b1;
    pre_addr = 9'h00A;
    pre_data = 9'h15A;
    @(posedge clk);
    #1;
    pre_we = 1'b0;
    set_cfg(EBR_ROM, W8, W8, 1'b0, 1'b0, 1'b0);
    ua.access(1'b1, 12'h00A, 36'hFF, 4'h1);
    rd(1'b1, 12'h00A, 1'b0, 36'h5A);
    set_cfg(EBR_TDP, W8, W8, 1'b1, 1'b0, 1'b0);
    rd(1'b0, 12'h00A, 1'b0, 36'h15A);
  endtask

  task automatic s_sdp();
    set_cfg(EBR_SDP, W8, W8, 1'b0, 1'b0, 1'b0);
    fork
      ua.access(1'b1, 12'h014, 36'h77, 4'h1);
      rd(1'b1, 12'h00A, 1'b0, 36'h5A);
    join
    rd(1'b1, 12'h014, 1'b0, 36'h77);
    ua.access(1'b0, 12'h014, 36'h0, 4'h0);
    repeat (2) begin
      @(posedge clk);
      #1;
      check({35'h0, a_rvld}, 36'h0, "write-only port answered");
    end
  endtask

  task automatic s_sp();
    set_cfg(EBR_SP, W8, W8, 1'b0, 1'b0, 1'b0);
    ub.access(1'b1, 12'h014, 36'hEE, 4'h1);
    rd(1'b0, 12'h014, 1'b0, 36'h77);
  endtask

  task automatic s_split();
    set_cfg(EBR_SPLIT, W8, W8, 1'b0, 1'b0, 1'b0);
    fork
      ua.access(1'b1, 12'h005, 36'h11, 4'h1);
      ub.access(1'b1, 12'h005, 36'h22, 4'h1);
    join
    rd(1'b0, 12'h005, 1'b0, 36'h11);
    rd(1'b1, 12'h005, 1'b0, 36'h22);
  endtask

  // uncaptured read address: valid already after the edge that sees en
  task automatic s_pseudo();
    set_cfg(EBR_SDP, W8, W8, 1'b0, 1'b0, 1'b0);
    cfg.pseudo_async = 1'b1;
    ub.access(1'b0, 12'h014, 36'h0, 4'h0);
    check({35'h0, b_rvld}, 36'h1, "early read valid");
    check(b_rdata, 36'h77, "early read data");
  endtask

  task automatic s_shift();
    set_cfg(EBR_SHIFT, W8, W8, 1'b0, 1'b0, 1'b0);
    set_taps(12'h002, 3'h1, 1'b0);
    ua.access(1'b1, 12'h000, 36'h3C, 4'h1);
    ua.access(1'b1, 12'h000, 36'h4D, 4'h1);
    ua.access(1'b1, 12'h000, 36'h5E, 4'h1);
    @(posedge clk);
    #1;
    check({35'h0, b_rvld}, 36'h1, "tap valid");
    check(b_rdata, 36'h3C, "tap data");
    set_taps(12'h001, 3'h2, 1'b0);
    ua.access(1'b1, 12'h000, 36'h6F, 4'h1);
    @(posedge clk);
    #1;
    check(b_rdata, 36'h4D5E, "two taps");
  endtask

  task automatic s_shapes();
    set_cfg(EBR_TDP, W32, W32, 1'b0, 1'b0, 1'b1);
    set_cfg(EBR_SDP, W32, W32, 1'b0, 1'b0, 1'b0);
    set_cfg(EBR_TDP, W4, W8, 1'b1, 1'b0, 1'b1);
    set_cfg(EBR_SHIFT, W16, W16, 1'b0, 1'b0, 1'b0);
    set_taps(12'h002, 3'h3, 1'b1);
    set_cfg(EBR_SHIFT, W32, W32, 1'b0, 1'b0, 1'b0);
    set_taps(12'h090, 3'h1, 1'b0);
    set_taps(12'h0C8, 3'h1, 1'b1);
  endtask

  initial begin
    #100000;
    error_cnt++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    complete_run();
  end

  initial begin
    repeat (4) @(posedge clk);
    #1;
    resetn = 1'b1;
    s_tdp();
    s_outreg();
    s_mixed();
    s_parity();
    s_rom();
    s_sdp();
    s_sp();
    s_split();
    s_pseudo();
    s_shift();
    s_shapes();
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
